// [rtl/i2c_slave.sv]
// i2c slave engine with its cpu register file
// assumes scl and sda arrive from open-drain pins in another domain; cpu port on sys_clk_i
`timescale 1ns/1ns
`default_nettype none
`include "i2c_slave_regs.svh"
module i2c_slave (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   output logic irq_o,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic [1:0] open_drain_select_o
);
   // two-stage synchronisers for the pins
   logic [1:0] scl_sync_r;
   logic [1:0] sda_sync_r;
   logic scl_prev_r; // previous synchronised clock level
   logic sda_prev_r; // previous synchronised data level
   i2c_slave_pkg::bus_view_type bus;
   // registers
   logic irq_flag_r;
   logic irq_enable_r;
   logic global_int_enable_r;
   logic [1:0] open_drain_select_r;
   logic write_collision_r;
   logic receive_overflow_r;
   logic module_enable_r;
   logic clock_release_r;
   logic byte_kind_flag_r;
   logic stop_seen_r;
   logic start_seen_r;
   logic read_mode_r;
   logic buffer_full_r;
   logic [7:0] own_address_r;
   logic [7:0] data_buffer_r;
   // engine
   i2c_slave_pkg::engine_state_type state_r;
   logic [7:0] shift_register_r;
   logic [3:0] bit_cnt_r;
   logic addr_phase_r; // the byte in flight is the address
   logic ack_ok_r; // acknowledge decision for this byte
   logic sda_low_r; // device pulls data low
   logic scl_low_r; // device pulls clock low
   // one-cycle events from the engine
   logic ev_addr_match;
   logic ev_data_in;
   logic ev_overflow;
   logic ev_tx_done;
   logic cpu_wr_buf;
   logic cpu_rd_buf;
   logic [7:0] byte_now;
   localparam logic [7:0] od_reset_img = `RST_OPEN_DRAIN; // open drain register image at reset

   // register address decode used by several processes
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   assign cpu_wr_buf = wr_i && hit(addr_i, `ADR_DATA_BUFFER);
   assign cpu_rd_buf = rd_i && hit(addr_i, `ADR_DATA_BUFFER);
   assign byte_now = {shift_register_r[6:0], bus.sda};

   // pin synchronisers; only the second stage is looked at
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         scl_sync_r <= 2'h3;
         sda_sync_r <= 2'h3;
         scl_prev_r <= 1'b1;
         sda_prev_r <= 1'b1;
      end else begin
         scl_sync_r <= {scl_sync_r[0], scl_i};
         sda_sync_r <= {sda_sync_r[0], sda_i};
         scl_prev_r <= scl_sync_r[1];
         sda_prev_r <= sda_sync_r[1];
      end
   end

   // bus view: levels, clock edges, start and stop
   always_comb begin
      bus.scl = scl_sync_r[1];
      bus.sda = sda_sync_r[1];
      bus.scl_rise = scl_sync_r[1] && !scl_prev_r;
      bus.scl_fall = !scl_sync_r[1] && scl_prev_r;
      bus.start = scl_sync_r[1] && scl_prev_r && !sda_sync_r[1] && sda_prev_r;
      bus.stop = scl_sync_r[1] && scl_prev_r && sda_sync_r[1] && !sda_prev_r;
   end

   // byte engine; the master owns clock and framing, see RQ1
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_r <= i2c_slave_pkg::ST_IDLE;
         shift_register_r <= `RST_ZERO;
         bit_cnt_r <= 4'h0;
         addr_phase_r <= 1'b0;
         ack_ok_r <= 1'b0;
         sda_low_r <= 1'b0;
      end else if (!module_enable_r) begin
         // disabled module ignores the bus, see RQ13
         state_r <= i2c_slave_pkg::ST_IDLE;
         sda_low_r <= 1'b0;
         bit_cnt_r <= 4'h0;
      end else if (bus.start) begin
         // a start always restarts address reception
         state_r <= i2c_slave_pkg::ST_RECV;
         bit_cnt_r <= 4'h0;
         addr_phase_r <= 1'b1;
         sda_low_r <= 1'b0;
      end else if (bus.stop) begin
         state_r <= i2c_slave_pkg::ST_IDLE;
         sda_low_r <= 1'b0;
      end else begin
         case (state_r)
            i2c_slave_pkg::ST_RECV: begin
               if (bus.scl_rise) begin
                  // sample one bit into the shift register, see RQ3
                  shift_register_r <= byte_now;
                  bit_cnt_r <= bit_cnt_r + 4'h1;
                  if (bit_cnt_r == `BITS_PER_BYTE - 4'h1) begin
                     if (addr_phase_r) begin
                        ack_ok_r <= (byte_now[7:1] == own_address_r[7:1]); // see RQ2
                     end else begin
                        ack_ok_r <= !buffer_full_r; // no ack into full buffer, see RQ10
                     end
                  end
               end else if (bus.scl_fall && bit_cnt_r == `BITS_PER_BYTE) begin
                  if (ack_ok_r) begin
                     sda_low_r <= 1'b1; // acknowledge low, see RQ7 RQ8
                     state_r <= i2c_slave_pkg::ST_ACK;
                  end else if (addr_phase_r) begin
                     state_r <= i2c_slave_pkg::ST_IDLE; // mismatch ignored, see RQ23
                  end else begin
                     state_r <= i2c_slave_pkg::ST_ACK; // overflow byte, data released
                  end
               end
            end
            i2c_slave_pkg::ST_ACK: begin
               if (bus.scl_fall) begin
                  sda_low_r <= 1'b0;
                  bit_cnt_r <= 4'h0;
                  if (addr_phase_r && shift_register_r[0]) begin
                     state_r <= i2c_slave_pkg::ST_HOLD; // transmit mode, see RQ6 RQ15
                  end else begin
                     state_r <= i2c_slave_pkg::ST_RECV;
                  end
                  addr_phase_r <= 1'b0;
               end
            end
            i2c_slave_pkg::ST_HOLD: begin
               if (clock_release_r && !bus.scl) begin
                  // first bit out only after release, see RQ16
                  // wait for a low clock: after a master ack the clock is still high here,
                  // and a data change then would look like a start or stop on the bus
                  shift_register_r <= data_buffer_r;
                  sda_low_r <= !data_buffer_r[7];
                  state_r <= i2c_slave_pkg::ST_SEND;
               end
            end
            i2c_slave_pkg::ST_SEND: begin
               if (bus.scl_fall) begin
                  bit_cnt_r <= bit_cnt_r + 4'h1;
                  if (bit_cnt_r == `BITS_PER_BYTE - 4'h1) begin
                     sda_low_r <= 1'b0;
                     state_r <= i2c_slave_pkg::ST_MACK;
                  end else begin
                     shift_register_r <= {shift_register_r[6:0], 1'b0};
                     sda_low_r <= !shift_register_r[6];
                  end
               end
            end
            i2c_slave_pkg::ST_MACK: begin
               if (bus.scl_rise) begin
                  // master ack low: next byte, else done
                  state_r <= bus.sda ? i2c_slave_pkg::ST_IDLE : i2c_slave_pkg::ST_HOLD;
                  bit_cnt_r <= 4'h0;
               end
            end
            default: begin
               state_r <= i2c_slave_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // one-cycle events at the end of each byte
   assign ev_addr_match = module_enable_r && !bus.start && !bus.stop && state_r == i2c_slave_pkg::ST_RECV
      && bus.scl_fall && bit_cnt_r == `BITS_PER_BYTE && addr_phase_r && ack_ok_r;
   assign ev_data_in = module_enable_r && !bus.start && !bus.stop && state_r == i2c_slave_pkg::ST_RECV
      && bus.scl_fall && bit_cnt_r == `BITS_PER_BYTE && !addr_phase_r && ack_ok_r;
   assign ev_overflow = module_enable_r && !bus.start && !bus.stop && state_r == i2c_slave_pkg::ST_RECV
      && bus.scl_fall && bit_cnt_r == `BITS_PER_BYTE && !addr_phase_r && !ack_ok_r;
   assign ev_tx_done = module_enable_r && !bus.start && !bus.stop && state_r == i2c_slave_pkg::ST_MACK
      && bus.scl_rise && !bus.sda;

   // clock stretch while holding for software in transmit mode
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         scl_low_r <= 1'b0;
      end else begin
         // clock held when release bit is zero, see RQ14 RQ15
         scl_low_r <= module_enable_r && !clock_release_r &&
                      (state_r == i2c_slave_pkg::ST_HOLD) && !bus.scl;
      end
   end

   // data buffer and its full flag
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         data_buffer_r <= `RST_ZERO;
         buffer_full_r <= 1'b0;
      end else begin
         if (ev_addr_match || ev_data_in) begin
            data_buffer_r <= shift_register_r; // see RQ3 RQ4 RQ5
            buffer_full_r <= 1'b1; // set wins over read, see RQ9
         end else if (cpu_wr_buf) begin
            data_buffer_r <= wdata_i; // see RQ4
            buffer_full_r <= 1'b1;
         end else if (ev_tx_done || cpu_rd_buf) begin
            buffer_full_r <= 1'b0; // see RQ8 RQ17
         end
      end
   end

   // status flags: direction, byte kind, start and stop
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         read_mode_r <= 1'b0;
         byte_kind_flag_r <= 1'b0;
         start_seen_r <= 1'b0;
         stop_seen_r <= 1'b0;
      end else begin
         if (ev_addr_match) begin
            read_mode_r <= shift_register_r[0]; // see RQ6
            byte_kind_flag_r <= 1'b0; // see RQ22
         end else if (ev_data_in) begin
            byte_kind_flag_r <= 1'b1; // see RQ22
         end
         if (!module_enable_r) begin
            start_seen_r <= 1'b0; // see RQ19
            stop_seen_r <= 1'b0;
         end else if (bus.start) begin
            start_seen_r <= 1'b1; // see RQ18
            stop_seen_r <= 1'b0;
         end else if (bus.stop) begin
            stop_seen_r <= 1'b1; // see RQ18
            start_seen_r <= 1'b0;
         end
      end
   end

   // control register; hardware sets of sticky error flags win over clears
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         write_collision_r <= 1'b0;
         receive_overflow_r <= 1'b0;
         module_enable_r <= 1'b0;
         clock_release_r <= 1'b1;
      end else begin
         if (wr_i && hit(addr_i, `ADR_CONTROL)) begin
            write_collision_r <= wdata_i[`BIT_WRITE_COLLISION];
            receive_overflow_r <= wdata_i[`BIT_RECEIVE_OVERFLOW]; // see RQ11
            module_enable_r <= wdata_i[`BIT_MODULE_ENABLE]; // see RQ13
            clock_release_r <= wdata_i[`BIT_CLOCK_RELEASE]; // see RQ14
         end
         if (ev_overflow) begin
            receive_overflow_r <= 1'b1; // see RQ10
         end
         if (cpu_wr_buf && (state_r == i2c_slave_pkg::ST_SEND || state_r == i2c_slave_pkg::ST_MACK)) begin
            write_collision_r <= 1'b1; // see RQ12
         end
      end
   end

   // interrupt, address, and open drain registers
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         irq_flag_r <= 1'b0;
         irq_enable_r <= 1'b0;
         global_int_enable_r <= 1'b0;
         own_address_r <= `RST_ZERO;
         open_drain_select_r <= {od_reset_img[`BIT_OD_SDA], od_reset_img[`BIT_OD_SCL]}; // see RQ21
      end else begin
         if (wr_i && hit(addr_i, `ADR_INT_FLAGS)) begin
            irq_flag_r <= wdata_i[`BIT_IRQ_FLAG];
         end
         if (ev_addr_match || ev_data_in || ev_tx_done) begin
            irq_flag_r <= 1'b1; // set wins over clear, see RQ7 RQ8 RQ17
         end
         if (wr_i && hit(addr_i, `ADR_INT_ENABLES)) begin
            irq_enable_r <= wdata_i[`BIT_IRQ_ENABLE];
            global_int_enable_r <= wdata_i[`BIT_GLOBAL_ENABLE];
         end
         if (wr_i && hit(addr_i, `ADR_OWN_ADDRESS)) begin
            own_address_r <= wdata_i;
         end
         if (wr_i && hit(addr_i, `ADR_OPEN_DRAIN)) begin
            open_drain_select_r <= {wdata_i[`BIT_OD_SDA], wdata_i[`BIT_OD_SCL]}; // see RQ21
         end
      end
   end

   // read data one cycle after the strobe; unmapped reads zero
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_o <= `RST_ZERO;
      end else if (!rd_i) begin
         rdata_o <= `RST_ZERO;
      end else if (hit(addr_i, `ADR_INT_FLAGS)) begin
         rdata_o <= {4'h0, irq_flag_r, 3'h0};
      end else if (hit(addr_i, `ADR_INT_ENABLES)) begin
         rdata_o <= {global_int_enable_r, 3'h0, irq_enable_r, 3'h0};
      end else if (hit(addr_i, `ADR_OPEN_DRAIN)) begin
         rdata_o <= {3'h0, open_drain_select_r, 3'h0};
      end else if (hit(addr_i, `ADR_CONTROL)) begin
         rdata_o <= {write_collision_r, receive_overflow_r, module_enable_r, clock_release_r, 4'h0};
      end else if (hit(addr_i, `ADR_STATUS)) begin
         rdata_o <= {2'h0, byte_kind_flag_r, stop_seen_r, start_seen_r, read_mode_r, 1'b0, buffer_full_r};
      end else if (hit(addr_i, `ADR_OWN_ADDRESS)) begin
         rdata_o <= own_address_r;
      end else if (hit(addr_i, `ADR_DATA_BUFFER)) begin
         rdata_o <= data_buffer_r;
      end else begin
         rdata_o <= `RST_ZERO;
      end
   end

   // registered pin and interrupt outputs
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         irq_o <= 1'b0;
         scl_o <= 1'b0;
         scl_oe_o <= 1'b0;
         sda_o <= 1'b0;
         sda_oe_o <= 1'b0;
         open_drain_select_o <= 2'h3;
      end else begin
         irq_o <= irq_flag_r && irq_enable_r && global_int_enable_r; // see RQ20
         scl_o <= 1'b0;
         scl_oe_o <= scl_low_r;
         sda_o <= 1'b0;
         sda_oe_o <= sda_low_r;
         open_drain_select_o <= open_drain_select_r;
      end
   end

   chk_mismatch_no_ack: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RQ23
      (state_r == i2c_slave_pkg::ST_IDLE) |-> ##1 !sda_low_r)
      else $error("data driven while idle");
   chk_addr_sets_full: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RQ5
      ev_addr_match |=> buffer_full_r && data_buffer_r == $past(shift_register_r))
      else $error("address not loaded to buffer");
   chk_match_ack_irq: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RQ7
      ev_addr_match |=> sda_low_r && irq_flag_r)
      else $error("matched address not acked");
   chk_overflow_sticky: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RQ11
      receive_overflow_r && !(wr_i && addr_i == `ADR_CONTROL) |=> receive_overflow_r)
      else $error("overflow cleared by hardware");
   chk_overflow_no_ack: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RQ10
      ev_overflow |=> receive_overflow_r && !sda_low_r)
      else $error("overflow byte mishandled");
   chk_disable_clears: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RQ19
      !module_enable_r |=> !start_seen_r && !stop_seen_r)
      else $error("start or stop kept while disabled");
   chk_release_frees: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RQ14
      clock_release_r |=> ##1 !scl_oe_o)
      else $error("clock held while released");
   chk_irq_gate: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RQ20
      irq_o |-> $past(irq_flag_r && irq_enable_r && global_int_enable_r))
      else $error("interrupt without enables");
   chk_tx_done: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RQ17
      ev_tx_done |=> !buffer_full_r && irq_flag_r)
      else $error("transmit end not flagged");
   cov_addr: cover property (@(posedge sys_clk_i) disable iff (!rstn_i) ev_addr_match);
   cov_data: cover property (@(posedge sys_clk_i) disable iff (!rstn_i) ev_data_in);
   cov_ovf: cover property (@(posedge sys_clk_i) disable iff (!rstn_i) ev_overflow);
   cov_tx: cover property (@(posedge sys_clk_i) disable iff (!rstn_i) ev_tx_done);
endmodule
`default_nettype wire

// [rtl/i2c_slave_regs.svh]
// register offsets, field positions, reset values and the bits per byte count of the i2c slave block
// assumes the cpu register port of the i2c slave block, byte-wide registers
//
// Behaviour
// RQ1: master drives clock, start, address, data
// RQ2: respond only when address matches own address
// RQ3: shift bits in, then move byte
// RQ4: one data buffer serves both directions
// RQ5: matched address loads buffer, sets full flag
// RQ6: direction bit selects transmit or receive mode
// RQ7: matched address acknowledged low, interrupt flag set
// RQ8: buffer read clears full, next byte acked
// RQ9: full flag holds until software reads
// RQ10: byte into full buffer: overflow, no ack
// RQ11: overflow flag cleared only by software
// RQ12: buffer write during transmit sets collision flag
// RQ13: control bit 5 enables whole module
// RQ14: clock release bit, one releases, resets one
// RQ15: transmit mode holds clock low after address; here only while the release bit is zero, hardware never clears it
// RQ16: shift out only after software releases clock
// RQ17: transmitted byte acked: clear full, interrupt
// RQ18: status bits flag stop and start
// RQ19: disabled module clears start and stop flags
// RQ20: interrupt flag gated by enable and global
// RQ21: open drain select bits reset to one
// RQ22: status bit 5 marks data versus address
// RQ23: mismatch: no ack, ignore until next start
`ifndef I2C_SLAVE_REGS_SVH
`define I2C_SLAVE_REGS_SVH
`define ADR_INT_FLAGS 8'h06
`define ADR_INT_ENABLES 8'h07
`define ADR_OPEN_DRAIN 8'h37
`define ADR_CONTROL 8'h57
`define ADR_STATUS 8'h58
`define ADR_OWN_ADDRESS 8'h59
`define ADR_DATA_BUFFER 8'h5A
`define BIT_IRQ_FLAG 3
`define BIT_IRQ_ENABLE 3
`define BIT_GLOBAL_ENABLE 7
`define BIT_OD_SCL 3
`define BIT_OD_SDA 4
`define BIT_WRITE_COLLISION 7
`define BIT_RECEIVE_OVERFLOW 6
`define BIT_MODULE_ENABLE 5
`define BIT_CLOCK_RELEASE 4
`define BIT_BYTE_KIND 5
`define BIT_STOP_SEEN 4
`define BIT_START_SEEN 3
`define BIT_READ_MODE 2
`define BIT_BUFFER_FULL 0
`define RST_OPEN_DRAIN 8'h18
`define RST_CONTROL 8'h10
`define RST_ZERO 8'h00
`define BITS_PER_BYTE 4'h8
`endif

// [rtl/i2c_slave_pkg.sv]
// types shared by the i2c slave block
// assumes the constants header for offsets and fields
`default_nettype none
package i2c_slave_pkg;
   // byte engine states, one-hot
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01, // waiting for start, or ignoring the transfer
      ST_RECV = 6'h02, // shifting a byte in
      ST_ACK = 6'h04, // driving or withholding acknowledge
      ST_HOLD = 6'h08, // waiting for software; clock held low only while the release bit is zero
      ST_SEND = 6'h10, // shifting a byte out
      ST_MACK = 6'h20 // reading master acknowledge
   } engine_state_type;
   // sampled bus levels and their edges
   typedef struct packed {
      logic scl;
      logic sda;
      logic scl_rise;
      logic scl_fall;
      logic start;
      logic stop;
   } bus_view_type;
endpackage
`default_nettype wire

// [test/i2c_master_model.sv]
// behavioural i2c bus master standing on the far side of the slave block
// assumes open-drain wires resolved by the bench from every party's pull-low enable
`timescale 1ns/1ns
`default_nettype none
module i2c_master_model (
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_oe_o,
   output logic sda_oe_o
);
   localparam int LOW_NS = 300; // long low phase leaves room for the slave's late ack drive
   localparam int HIGH_NS = 100; // high phase, 400 ns bit period in all
   initial begin
      scl_oe_o = 1'b0;
      sda_oe_o = 1'b0;
   end
   // release the clock, then wait, bounded, while the slave stretches it
   task automatic rise();
      int i;
      scl_oe_o = 1'b0;
      i = 0;
      while (!scl_i && i < 40000) begin
         #10;
         i++;
      end
   endtask
   // start: data falls while the clock is high
   task automatic start_cond();
      sda_oe_o = 1'b0;
      #(LOW_NS);
      rise();
      #(HIGH_NS);
      sda_oe_o = 1'b1;
      #(HIGH_NS);
      scl_oe_o = 1'b1;
      #50;
   endtask
   // stop: data rises while the clock is high
   task automatic stop_cond();
      sda_oe_o = 1'b1;
      #(LOW_NS - 50);
      rise();
      #(HIGH_NS);
      sda_oe_o = 1'b0;
      #(HIGH_NS);
   endtask
   // one bit: drive b (1 releases), sample the wire mid-high
   task automatic bit_cycle(input logic b, output logic s);
      sda_oe_o = ~b;
      #(LOW_NS - 50);
      rise();
      #50;
      s = sda_i;
      #(HIGH_NS - 50);
      scl_oe_o = 1'b1;
      #50;
   endtask
   // address or data byte out, msb first, then read the slave's ack
   task automatic write_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(d[i], s);
      end
      bit_cycle(1'b1, s);
      ack = ~s;
   endtask
   // byte in from the slave, then ack (1) or nack (0)
   task automatic read_byte(input logic ack_send, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(1'b1, d[i]);
      end
      bit_cycle(~ack_send, s);
   endtask
endmodule
`default_nettype wire

// [test/i2c_slave_module_tb.sv]
// self-checking bench for the i2c slave block, register port driven here
// assumes the master model drives the far side; reads are checked from a queue of notes
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_module_tb;
   typedef struct packed {
      logic [7:0] adr;
      logic [7:0] exp;
      logic [7:0] msk;
   } note_type; // one expected register read
   localparam logic [7:0] RST_A [9] = '{8'h06, 8'h07, 8'h37, 8'h57, 8'h58, 8'h59, 8'h5A, 8'h00, 8'h55};
   localparam logic [7:0] RST_V [9] = '{8'h00, 8'h00, 8'h18, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] RST_M [9] = '{8'h08, 8'h88, 8'h18, 8'hF0, 8'h3D, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
   logic sys_clk = 1'b0; // system clock
   logic rstn = 1'b0; // active-low reset
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rd_d = 1'b0; // read taken last edge: data due now
   logic [7:0] rdata;
   logic irq, scl_oe, sda_oe, m_scl_oe, m_sda_oe;
   logic [1:0] od_sel;
   logic [1:0] pin_lo; // levels driven onto the clock and data pins
   wire scl = ~(scl_oe | m_scl_oe); // pulled-up wire, low while any party pulls
   wire sda = ~(sda_oe | m_sda_oe);
   note_type notes[$]; // expected reads in issue order
   note_type cur;
   int n_errors = 0;
   int cmp_count = 0;
   logic [31:0] seed = 32'hEA14345B;
   logic [7:0] d1, d2, tx, got;
   logic ack;
   always #25 sys_clk = ~sys_clk;
   i2c_slave DUT (.sys_clk_i(sys_clk), .rstn_i(rstn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .irq_o(irq), .scl_i(scl), .scl_o(pin_lo[1]), .scl_oe_o(scl_oe), .sda_i(sda),
      .sda_o(pin_lo[0]), .sda_oe_o(sda_oe), .open_drain_select_o(od_sel));
   i2c_master_model master (.scl_i(scl), .sda_i(sda), .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe));
   // xorshift source for data bytes
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", what, e, g);
         n_errors++;
      end
   endtask
   // one-cycle write strobe
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask
   // one-cycle read strobe; the watcher compares the data a cycle later
   task automatic rreg(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      notes.push_back('{a, e, m});
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
   endtask
   task automatic irq_is(input logic e);
      repeat (3) @(negedge sys_clk);
      chk("irq", {7'h00, e}, {7'h00, irq});
   endtask
   always @(posedge sys_clk) rd_d <= rd;
   // watcher: read data stand only in the cycle after the strobe
   always @(negedge sys_clk) begin
      if (rd_d) begin
         cur = notes.pop_front();
         chk($sformatf("reg %h", cur.adr), cur.exp & cur.msk, rdata & cur.msk);
      end
   end
   task automatic results();
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // watchdog against a hung handshake or stretched clock
   initial begin
      #2000000;
      n_errors++;
      results();
   end
   initial begin
      repeat (5) @(posedge sys_clk);
      rstn <= 1'b1;
      // reset values and unmapped offsets
      for (int i = 0; i < 9; i++) begin
         rreg(RST_A[i], RST_V[i], RST_M[i]);
      end
      chk("od sel", 8'h03, {6'h00, od_sel});
      wreg(8'h37, 8'h00);
      rreg(8'h37, 8'h00, 8'h18);
      chk("od sel", 8'h00, {6'h00, od_sel});
      wreg(8'h59, 8'hA4);
      // disabled module ignores a matching address
      master.start_cond();
      master.write_byte(8'hA4, ack);
      chk("ack", 8'h00, {7'h00, ack});
      master.stop_cond();
      rreg(8'h58, 8'h00, 8'h18);
      wreg(8'h57, 8'h30);
      wreg(8'h07, 8'h08);
      // receive: address, one read byte, one held byte, one overflowing byte
      master.start_cond();
      master.write_byte(8'hA4, ack);
      chk("ack", 8'h01, {7'h00, ack});
      irq_is(1'b0);
      wreg(8'h07, 8'h88);
      irq_is(1'b1);
      rreg(8'h06, 8'h08, 8'h08);
      rreg(8'h58, 8'h09, 8'h3D);
      rreg(8'h5A, 8'hA4, 8'hFF);
      wreg(8'h06, 8'h00);
      d1 = rnd();
      master.write_byte(d1, ack);
      chk("ack", 8'h01, {7'h00, ack});
      rreg(8'h58, 8'h29, 8'h3D);
      rreg(8'h5A, d1, 8'hFF);
      rreg(8'h58, 8'h00, 8'h01);
      d2 = rnd();
      master.write_byte(d2, ack);
      chk("ack", 8'h01, {7'h00, ack});
      wreg(8'h06, 8'h00);
      rreg(8'h58, 8'h01, 8'h01);
      master.write_byte(rnd(), ack);
      chk("ack", 8'h00, {7'h00, ack});
      rreg(8'h06, 8'h00, 8'h08);
      rreg(8'h5A, d2, 8'hFF);
      rreg(8'h57, 8'h70, 8'hF0);
      wreg(8'h57, 8'h30);
      rreg(8'h57, 8'h30, 8'hF0);
      master.stop_cond();
      rreg(8'h58, 8'h10, 8'h18);
      // foreign address: no ack for it nor for what follows
      master.start_cond();
      master.write_byte(8'h52, ack);
      chk("ack", 8'h00, {7'h00, ack});
      master.write_byte(rnd(), ack);
      chk("ack", 8'h00, {7'h00, ack});
      master.stop_cond();
      // transmit: clock held until software loads the byte and releases it
      wreg(8'h57, 8'h20);
      master.start_cond();
      master.write_byte(8'hA5, ack);
      chk("ack", 8'h01, {7'h00, ack});
      tx = rnd();
      fork
         master.read_byte(1'b1, got);
         begin
            repeat (20) @(negedge sys_clk);
            chk("scl hold", 8'h01, {7'h00, scl_oe});
            rreg(8'h58, 8'h0D, 8'h1D);
            wreg(8'h06, 8'h00);
            wreg(8'h5A, tx);
            wreg(8'h57, 8'h30);
         end
      join
      chk("tx byte", tx, got);
      rreg(8'h58, 8'h0C, 8'h1D);
      rreg(8'h06, 8'h08, 8'h08);
      // a buffer write in mid-shift collides
      fork
         master.read_byte(1'b0, got);
         begin
            repeat (40) @(posedge sys_clk);
            wreg(8'h5A, 8'h5A);
         end
      join
      chk("tx again", tx, got);
      rreg(8'h57, 8'hB0, 8'hF0);
      wreg(8'h57, 8'h30);
      rreg(8'h57, 8'h30, 8'hF0);
      master.stop_cond();
      // disabling wipes start and stop flags
      wreg(8'h57, 8'h10);
      rreg(8'h58, 8'h00, 8'h18);
      repeat (3) @(posedge sys_clk);
      chk("pin level", 8'h00, {6'h00, pin_lo});
      results();
   end
endmodule
`default_nettype wire
